// >>> design/rtc_pkg.sv
// Constants shared by the clock/calendar and reset supervisor core.
// Assumes a 125 MHz system clock and a separate oscillator clock domain.
// Behaviour
// - First battery power keeps oscillator stopped until supply good or address match.
// - About 2s after supply or address match, request temperature trim and apply it.
// - First supply power-up or first address match loads 01/01/00 day 01 00:00:00.
// - Oscillator disable bit at 1 stops the oscillator and timekeeping.
// - Outside reset cycle, falling reset pin edge drives pin low for debounce.
// - After debounce, wait for rising edge then drive pin low for hold time.
// - Supply below threshold holds the reset pin low.
// - Supply recovery keeps reset pin low for about 250ms before release.
// - Oscillator stopped at supply recovery: release reset pin immediately.
// - Reset pin logic runs only with supply; reset never disturbs timekeeping.
// - Select bit routes output pin to alarm interrupt or 1Hz square wave.
// - 236 bytes of read/write storage at bus addresses 14h to FFh.
// - Multibyte pointer wraps from 12h back to 00h.
// - START or pointer roll to 00h copies time into read buffers.
// - All time and calendar fields are BCD.
// - Hours bit 6 selects 12-hour mode; bit 5 is PM or twenty-hours.
// - Century bit 7 of month toggles when year rolls 99 to 00.
// - Weekday advances at midnight through sequential values.
// - Date rolls correctly for short months and leap February.
// - Seconds write restarts countdown chain; writes take effect at acknowledge.
package rtc_pkg;
    localparam int        SYS_CLK_HZ   = 125_000_000;
    localparam int        RECOVER_MS   = 250;
    localparam int        COMP_DELAY_S = 2;
    localparam longint    RECOVER_CYC  = (longint'(RECOVER_MS) * SYS_CLK_HZ) / 1000;
    localparam longint    COMP_CYC     = longint'(COMP_DELAY_S) * SYS_CLK_HZ;
    localparam int        OSC_HZ       = 32768;
    // Time register indices
    localparam int        T_SEC = 0;
    localparam int        T_MIN = 1;
    localparam int        T_HR  = 2;
    localparam int        T_DOW = 3;
    localparam int        T_DAT = 4;
    localparam int        T_MON = 5;
    localparam int        T_YR  = 6;
    localparam int        T_NUM = 7;
    localparam logic [7:0] REG_LAST    = 8'h12;
    localparam logic [7:0] TIME_LAST   = 8'h06;
    localparam logic [7:0] SRAM_FIRST  = 8'h14;
    localparam int        HR_MODE_BIT  = 6;
    localparam int        HR_PM_BIT    = 5;
    localparam int        MON_CENT_BIT = 7;
    localparam logic [7:0] INIT_SEC = 8'h00;
    localparam logic [7:0] INIT_ONE = 8'h01;
    localparam logic [7:0] BCD_59   = 8'h59;
    localparam logic [7:0] BCD_23   = 8'h23;
    localparam logic [7:0] BCD_12   = 8'h12;
    localparam logic [7:0] BCD_11   = 8'h11;
    localparam logic [7:0] BCD_07   = 8'h07;
    localparam logic [7:0] BCD_99   = 8'h99;
    localparam logic [7:0] BCD_28   = 8'h28;
    localparam logic [7:0] BCD_29   = 8'h29;
    localparam logic [7:0] BCD_30   = 8'h30;
    localparam logic [7:0] BCD_31   = 8'h31;
    localparam logic [6:0] DEV_ADDR_DEF = 7'h2A;  // Arbitrary bus address
endpackage

// >>> design/rtc_core.sv
// Clock/calendar, bus register access and reset supervisor of the RTC.
// Assumes scl, sda, rst pin and supply-good arrive asynchronously;
// osc_clk is the free-running internal oscillator clock.
`timescale 1ns/1ps
module rtc_core
    import rtc_pkg::*;
#(
    parameter logic [6:0]  DEV_ADDR     = DEV_ADDR_DEF,
    parameter int          OSC_DIV      = OSC_HZ,
    parameter logic [31:0] DEBOUNCE_CYC = 32'h0000_1000,
    parameter logic [31:0] HOLD_CYC     = 32'h0000_1000,
    parameter logic [31:0] RECOVER_LEN  = 32'(RECOVER_CYC),
    parameter logic [31:0] COMP_LEN     = 32'(COMP_CYC)
) (
    input  wire logic       sys_clk,         // System clock
    input  wire logic       nrst,            // Synchronous reset, active low
    input  wire logic       osc_clk,         // Oscillator clock
    input  wire logic       vcc_ok,          // Supply above power_fail_threshold
    input  wire logic       osc_disable_n,   // 1 stops oscillator
    input  wire logic       irq_wave_select, // 1 alarm interrupt, 0 square wave
    input  wire logic       alarm_irq,       // Alarm interrupt level, active high
    input  wire logic [7:0] comp_code,       // Temperature trim from sensor
    output logic            comp_req,        // Temperature measurement pulse
    output logic      [7:0] comp_trim,       // Trim applied to oscillator
    output logic            irq_wave_out,    // Interrupt/square-wave pin level
    input  wire logic       scl_in,          // Serial clock pin
    input  wire logic       sda_in,          // Serial data pin
    output logic            sda_out,         // Serial data drive level
    output logic            sda_oe,          // Serial data drive enable
    input  wire logic       rst_in,          // Reset pin level
    output logic            rst_out,         // Reset pin drive level
    output logic            rst_oe           // Reset pin drive enable
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] ptr_inc(input logic [7:0] p);
        ptr_inc = (p == REG_LAST) ? 8'h00 : p + 8'h01;
    endfunction

    function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        unique case (mon[4:0])
            5'h02:                      month_end = leap ? BCD_29 : BCD_28;
            5'h04, 5'h06, 5'h09, 5'h11: month_end = BCD_30;
            default:                    month_end = BCD_31;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Oscillator domain: countdown chain and 1Hz square wave
    // ------------------------------------------------------------
    logic [1:0]  o_rst_sync;
    logic [1:0]  o_run_sync;
    logic [2:0]  o_clr_sync;
    logic [31:0] o_div_reg;
    logic        o_tick_tgl_reg;
    logic        o_sqw_reg;
    logic        run_reg;
    logic        chain_clr_tgl_reg;
    wire         o_clr = o_clr_sync[2] ^ o_clr_sync[1];

    always_ff @(posedge osc_clk) begin
        o_rst_sync <= {o_rst_sync[0], nrst};
        o_run_sync <= {o_run_sync[0], run_reg};
        o_clr_sync <= {o_clr_sync[1:0], chain_clr_tgl_reg};
    end

    always_ff @(posedge osc_clk) begin
        if (!o_rst_sync[1]) begin
            o_div_reg      <= 32'h0000_0000;
            o_tick_tgl_reg <= 1'b0;
            o_sqw_reg      <= 1'b0;
        end else if (o_clr) begin
            o_div_reg <= 32'h0000_0000;
            o_sqw_reg <= 1'b0;
        end else if (o_run_sync[1]) begin
            if (o_div_reg == 32'(OSC_DIV - 1)) begin
                o_div_reg      <= 32'h0000_0000;
                o_tick_tgl_reg <= ~o_tick_tgl_reg;
            end else begin
                o_div_reg <= o_div_reg + 32'h0000_0001;
            end
            o_sqw_reg <= (o_div_reg < 32'(OSC_DIV / 2));
        end
    end

    // ------------------------------------------------------------
    // Pin and crossing synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_s, sda_s, rst_s, vcc_s, sqw_s;
    logic [2:0] tick_s;
    logic       scl_d, sda_d, rst_d, vcc_d;

    always_ff @(posedge sys_clk) begin
        scl_s  <= {scl_s[0], scl_in};
        sda_s  <= {sda_s[0], sda_in};
        rst_s  <= {rst_s[0], rst_in};
        vcc_s  <= {vcc_s[0], vcc_ok};
        sqw_s  <= {sqw_s[0], o_sqw_reg};
        tick_s <= {tick_s[1:0], o_tick_tgl_reg};
        scl_d  <= scl_s[1];
        sda_d  <= sda_s[1];
        rst_d  <= rst_s[1];
        vcc_d  <= vcc_s[1];
    end

    wire sec_tick  = tick_s[2] ^ tick_s[1];
    wire scl_rise  = scl_s[1] & ~scl_d;
    wire scl_fall  = ~scl_s[1] & scl_d;
    wire bus_start = scl_s[1] & scl_d & sda_d & ~sda_s[1];
    wire bus_stop  = scl_s[1] & scl_d & ~sda_d & sda_s[1];
    wire vcc_rise  = vcc_s[1] & ~vcc_d;
    wire rst_fall  = rst_d & ~rst_s[1];
    wire rst_rise  = ~rst_d & rst_s[1];

    // ------------------------------------------------------------
    // Serial register access
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        B_IDLE = 5'b00001,
        B_ADDR = 5'b00010,
        B_PTR  = 5'b00100,
        B_WR   = 5'b01000,
        B_RD   = 5'b10000
    } bus_state_e;

    bus_state_e bus_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic       sda_oe_reg;
    logic [7:0] mem [0:255];
    logic [7:0] tm_reg [0:T_NUM-1];
    logic [7:0] snap_reg [0:T_NUM-1];
    logic       armed_reg;

    wire        ack_phase = (bit_cnt_reg == 4'h8) & scl_fall;
    wire        end_ack   = (bit_cnt_reg == 4'h9) & scl_fall;
    wire        addr_hit  = (shift_reg[7:1] == DEV_ADDR);
    wire        do_write  = ack_phase & (bus_reg == B_WR);
    wire        is_time   = (ptr_reg <= TIME_LAST);
    wire [7:0]  rd_byte   = is_time ? snap_reg[ptr_reg[2:0]] : mem[ptr_reg];
    wire        ptr_wrap  = (ptr_reg == REG_LAST);
    wire        adv_ptr   = do_write | (end_ack & (bus_reg == B_RD));
    wire        snap_now  = bus_start | (adv_ptr & ptr_wrap);
    wire        addr_ok   = ack_phase & (bus_reg == B_ADDR) & addr_hit;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            bus_reg     <= B_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            tx_reg      <= 8'h00;
            ptr_reg     <= 8'h00;
            sda_oe_reg  <= 1'b0;
        end else if (bus_start) begin
            bus_reg     <= B_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg  <= 1'b0;
        end else if (bus_stop) begin
            bus_reg    <= B_IDLE;
            sda_oe_reg <= 1'b0;
        end else if (bus_reg != B_IDLE) begin
            if (scl_rise && bit_cnt_reg < 4'h8) begin
                shift_reg   <= {shift_reg[6:0], sda_s[1]};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_rise && bus_reg == B_RD && sda_s[1]) begin
                bus_reg <= B_IDLE;                       // Host refused next byte
            end
            if (ack_phase) begin
                bit_cnt_reg <= 4'h9;
                unique case (bus_reg)
                    B_ADDR: begin
                        sda_oe_reg <= addr_hit;
                        bus_reg    <= !addr_hit ? B_IDLE : (shift_reg[0] ? B_RD : B_PTR);
                    end
                    B_PTR: begin
                        sda_oe_reg <= 1'b1;
                        ptr_reg    <= shift_reg;
                        bus_reg    <= B_WR;
                    end
                    B_WR: begin
                        sda_oe_reg <= 1'b1;
                        ptr_reg    <= ptr_inc(ptr_reg);
                    end
                    default: sda_oe_reg <= 1'b0;
                endcase
            end else if (end_ack) begin
                bit_cnt_reg <= 4'h0;
                if (bus_reg == B_RD) begin
                    tx_reg     <= {rd_byte[6:0], 1'b0};
                    sda_oe_reg <= ~rd_byte[7];
                    ptr_reg    <= ptr_inc(ptr_reg);
                end else begin
                    sda_oe_reg <= 1'b0;
                end
            end else if (scl_fall && bus_reg == B_RD) begin
                tx_reg     <= {tx_reg[6:0], 1'b0};
                sda_oe_reg <= ~tx_reg[7];
            end
        end
    end

    // Storage behind the bus; no reset so retained data is never wiped
    always_ff @(posedge sys_clk) begin
        if (do_write && !is_time)
            mem[ptr_reg] <= shift_reg;
    end

    // ------------------------------------------------------------
    // Clock and calendar
    // ------------------------------------------------------------
    logic [7:0] nx_sec, nx_min, nx_hr, nx_dow, nx_dat, nx_mon, nx_yr;
    logic       c_min, c_hr, c_day, c_mon, c_yr;
    wire  [7:0] hr = tm_reg[T_HR];
    wire        h12 = hr[HR_MODE_BIT];

    always_comb begin
        c_min  = (tm_reg[T_SEC] == BCD_59);
        nx_sec = c_min ? INIT_SEC : bcd_inc(tm_reg[T_SEC]);
        c_hr   = c_min & (tm_reg[T_MIN] == BCD_59);
        nx_min = !c_min ? tm_reg[T_MIN] : (c_hr ? INIT_SEC : bcd_inc(tm_reg[T_MIN]));
        nx_hr  = hr;
        c_day  = 1'b0;
        if (c_hr) begin
            if (h12) begin
                if ({3'b000, hr[4:0]} == BCD_12)
                    nx_hr = {hr[7:5], INIT_ONE[4:0]};
                else if ({3'b000, hr[4:0]} == BCD_11) begin
                    nx_hr = {hr[7:6], ~hr[HR_PM_BIT], BCD_12[4:0]};
                    c_day = hr[HR_PM_BIT];
                end else
                    nx_hr = {hr[7:5], 5'h00} | (bcd_inc({3'b000, hr[4:0]}) & 8'h1F);
            end else if ({2'b00, hr[5:0]} == BCD_23) begin
                nx_hr = {hr[7:6], INIT_SEC[5:0]};
                c_day = 1'b1;
            end else
                nx_hr = {hr[7:6], 6'h00} | (bcd_inc({2'b00, hr[5:0]}) & 8'h3F);
        end
        nx_dow = !c_day ? tm_reg[T_DOW]
               : ((tm_reg[T_DOW] == BCD_07) ? INIT_ONE : bcd_inc(tm_reg[T_DOW]));
        c_mon  = c_day & (tm_reg[T_DAT] == month_end({3'b000, tm_reg[T_MON][4:0]},
                                                       tm_reg[T_YR]));
        nx_dat = !c_day ? tm_reg[T_DAT] : (c_mon ? INIT_ONE : bcd_inc(tm_reg[T_DAT]));
        c_yr   = c_mon & ({3'b000, tm_reg[T_MON][4:0]} == BCD_12);
        nx_mon = tm_reg[T_MON];
        if (c_mon)
            nx_mon = c_yr ? {tm_reg[T_MON][MON_CENT_BIT] ^ (tm_reg[T_YR] == BCD_99),
                             INIT_ONE[6:0]}
                          : ({tm_reg[T_MON][7:5], 5'h00}
                             | (bcd_inc({3'b000, tm_reg[T_MON][4:0]}) & 8'h1F));
        nx_yr  = !c_yr ? tm_reg[T_YR] : ((tm_reg[T_YR] == BCD_99) ? INIT_SEC
                                        : bcd_inc(tm_reg[T_YR]));
    end

    wire first_arm = ~armed_reg & (vcc_s[1] | addr_ok);

    always_ff @(posedge sys_clk) begin
        if (!nrst || first_arm) begin
            tm_reg[T_SEC] <= INIT_SEC;
            tm_reg[T_MIN] <= INIT_SEC;
            tm_reg[T_HR]  <= INIT_SEC;
            tm_reg[T_DOW] <= INIT_ONE;
            tm_reg[T_DAT] <= INIT_ONE;
            tm_reg[T_MON] <= INIT_ONE;
            tm_reg[T_YR]  <= INIT_SEC;
        end else if (do_write && is_time) begin
            tm_reg[ptr_reg[2:0]] <= shift_reg;
        end else if (sec_tick) begin
            tm_reg[T_SEC] <= nx_sec;
            tm_reg[T_MIN] <= nx_min;
            tm_reg[T_HR]  <= nx_hr;
            tm_reg[T_DOW] <= nx_dow;
            tm_reg[T_DAT] <= nx_dat;
            tm_reg[T_MON] <= nx_mon;
            tm_reg[T_YR]  <= nx_yr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (snap_now)
            snap_reg <= tm_reg;
    end

    // ------------------------------------------------------------
    // Oscillator run control and temperature trim
    // ------------------------------------------------------------
    logic [31:0] comp_cnt_reg;
    logic        comp_req_reg;
    logic [7:0]  comp_trim_reg;
    wire         comp_start = vcc_rise | addr_ok;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            armed_reg         <= 1'b0;
            run_reg           <= 1'b0;
            chain_clr_tgl_reg <= 1'b0;
            comp_cnt_reg      <= 32'h0000_0000;
            comp_req_reg      <= 1'b0;
            comp_trim_reg     <= 8'h00;
        end else begin
            armed_reg    <= armed_reg | first_arm;
            run_reg      <= (armed_reg | first_arm) & ~osc_disable_n;
            comp_req_reg <= (comp_cnt_reg == 32'h0000_0001);
            if (do_write && ptr_reg == 8'(T_SEC))
                chain_clr_tgl_reg <= ~chain_clr_tgl_reg;
            if (comp_start)
                comp_cnt_reg <= COMP_LEN;
            else if (comp_cnt_reg != 32'h0000_0000)
                comp_cnt_reg <= comp_cnt_reg - 32'h0000_0001;
            if (comp_req_reg)
                comp_trim_reg <= comp_code;
        end
    end

    // ------------------------------------------------------------
    // Reset supervisor
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        S_IDLE     = 6'b000001,
        S_DEBOUNCE = 6'b000010,
        S_WAITRISE = 6'b000100,
        S_HOLD     = 6'b001000,
        S_PFAIL    = 6'b010000,
        S_RECOVER  = 6'b100000
    } sup_state_e;

    sup_state_e  sup_reg;
    logic [31:0] sup_cnt_reg;
    logic        rst_oe_reg;
    logic        wave_reg;
    wire         sup_done = (sup_cnt_reg == 32'h0000_0000);
    sup_state_e  sup_next;

    // Timekeeping never looks at this state machine, so reset is harmless
    always_comb begin
        sup_next = sup_reg;
        unique case (sup_reg)
            S_IDLE:     if (rst_fall) sup_next = S_DEBOUNCE;
            S_DEBOUNCE: if (sup_done) sup_next = S_WAITRISE;
            S_WAITRISE: if (rst_rise) sup_next = S_HOLD;
            S_HOLD:     if (sup_done) sup_next = S_IDLE;
            S_PFAIL:    sup_next = run_reg ? S_RECOVER : S_IDLE;
            S_RECOVER:  if (sup_done) sup_next = S_IDLE;
            default:    sup_next = S_PFAIL;
        endcase
        if (!vcc_s[1])
            sup_next = S_PFAIL;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sup_reg     <= S_PFAIL;
            sup_cnt_reg <= 32'h0000_0000;
            rst_oe_reg  <= 1'b1;
            wave_reg    <= 1'b1;
        end else begin
            sup_reg     <= sup_next;
            rst_oe_reg  <= (sup_next != S_IDLE) && (sup_next != S_WAITRISE);
            wave_reg    <= irq_wave_select ? ~alarm_irq : sqw_s[1];
            if (sup_next != sup_reg)
                sup_cnt_reg <= (sup_next == S_DEBOUNCE) ? DEBOUNCE_CYC
                             : (sup_next == S_HOLD) ? HOLD_CYC
                             : (sup_next == S_RECOVER) ? RECOVER_LEN : 32'h0000_0000;
            else if (!sup_done)
                sup_cnt_reg <= sup_cnt_reg - 32'h0000_0001;
        end
    end

    assign rst_out      = 1'b0;
    assign rst_oe       = rst_oe_reg;
    assign sda_out      = 1'b0;
    assign sda_oe       = sda_oe_reg;
    assign comp_req     = comp_req_reg;
    assign comp_trim    = comp_trim_reg;
    assign irq_wave_out = wave_reg;
endmodule

// >>> verification/rtc_core_monitor.sv
// Concurrent checks on the rtc_core ports.
// Assumes reset and data pins resolve with pull-ups outside.
`timescale 1ns/1ps
module rtc_core_monitor (
    input wire logic       sys_clk,         // System clock
    input wire logic       nrst,            // Sync reset, active low
    input wire logic       vcc_ok,          // Supply good
    input wire logic       irq_wave_select, // Pin source select
    input wire logic       alarm_irq,       // Alarm level
    input wire logic [7:0] comp_code,       // Sensor trim
    input wire logic       comp_req,        // Measurement pulse
    input wire logic [7:0] comp_trim,       // Applied trim
    input wire logic       irq_wave_out,    // Interrupt pin level
    input wire logic       scl_in,          // Serial clock pin
    input wire logic       sda_oe,          // Data drive enable
    input wire logic       rst_in,          // Reset pin level
    input wire logic       rst_oe           // Reset pin drive
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_pf_holds_pin: assert property ((!vcc_ok)[*6] |-> rst_oe)
        else $error("reset pin free during power fail");
    a_comp_one_pulse: assert property (comp_req |=> !comp_req)
        else $error("measurement request longer than one cycle");
    a_trim_capture: assert property (comp_req |-> ##2 comp_trim == $past(comp_code))
        else $error("trim not taken from sensor");
    a_trim_steady: assert property (!$past(comp_req) && !$past(comp_req, 2)
        && !$past(comp_req, 3) |-> $stable(comp_trim))
        else $error("trim changed without a measurement");
    a_wave_alarm: assert property ((irq_wave_select && $stable(irq_wave_select)
        && $stable(alarm_irq))[*5] |-> irq_wave_out == !alarm_irq)
        else $error("pin does not follow alarm");
    a_button_grab: assert property ($fell(rst_in) && !rst_oe && vcc_ok
        |-> ##[1:8] rst_oe)
        else $error("button edge not debounced");
    a_pin_stretch: assert property ($rose(rst_oe) && vcc_ok && $past(vcc_ok, 6)
        |-> rst_oe[*8])
        else $error("reset pulse too short");
    a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line moved while clock high");
    c_comp: cover property (comp_req);
    c_ack: cover property ($rose(sda_oe));
    c_button: cover property ($rose(rst_oe) && vcc_ok);
endmodule

bind rtc_core rtc_core_monitor mon (.sys_clk, .nrst, .vcc_ok, .irq_wave_select, .alarm_irq,
    .comp_code, .comp_req, .comp_trim, .irq_wave_out, .scl_in, .sda_oe, .rst_in, .rst_oe);

// >>> verification/i2c_host_model.sv
// Bus host and pushbutton in front of rtc_core.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module i2c_host_model (
    input  wire logic sys_clk, // Pacing clock
    input  wire logic sda_bus, // Resolved data line
    output logic      scl,     // Serial clock
    output logic      sda_low, // High pulls data low
    output logic      btn      // Button closed
);
    // -----------
    // Bus cycles
    // -----------
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        btn = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic push(input logic v);
        btn = v;
    endtask
    task automatic start();
        sda_low = 1'b0;
        while (sda_bus !== 1'b1) begin
            scl = ~scl;
            wt(5);
        end
        scl = 1'b1;
        wt(5);
        sda_low = 1'b1;
        wt(5);
        scl = 1'b0;
        wt(4);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        wt(4);
        scl = 1'b1;
        wt(5);
        sda_low = 1'b0;
        wt(5);
    endtask
    // Data settles five cycles before the clock rises, as long as the clock then stays high
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        wt(5);
        scl = 1'b1;
        wt(5);
        r = sda_bus;
        scl = 1'b0;
        wt(4);
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    endtask
endmodule

// >>> verification/test_rtc_core.sv
// Self-checking bench for rtc_core driven through the bus host model.
// Assumes shortened counts: debounce and hold 50, recovery and trim delay 200.
`timescale 1ns/1ps
module test_rtc_core;
    import rtc_pkg::*;
    logic       sys_clk, osc_clk, nrst, vcc_ok, osc_disable_n, irq_wave_select, alarm_irq;
    logic       comp_req, irq_wave_out, sda_out, sda_oe, rst_out, rst_oe, scl, sda_low, btn;
    logic [7:0] comp_trim, comp_code;
    logic [1:0] seen_wave;
    int         err_total, n_compared;
    logic [7:0] init_v [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    logic [7:0] addr_v [3] = '{8'h14, 8'h15, 8'hFF};
    wire        sda_in = (sda_oe ? sda_out : 1'b1) && !sda_low;
    wire        rst_in = (rst_oe ? rst_out : 1'b1) && !btn;
    // ------
    // Tests
    // ------
    rtc_core #(.OSC_DIV(32'h10), .DEBOUNCE_CYC(32'h32), .HOLD_CYC(32'h32),
               .RECOVER_LEN(32'hC8), .COMP_LEN(32'hC8)) uut (
        .sys_clk, .nrst, .osc_clk, .vcc_ok, .osc_disable_n, .irq_wave_select, .alarm_irq,
        .comp_code, .comp_req, .comp_trim, .irq_wave_out, .scl_in(scl), .sda_in,
        .sda_out, .sda_oe, .rst_in, .rst_out, .rst_oe);
    i2c_host_model host (.sys_clk, .sda_bus(sda_in), .scl, .sda_low, .btn);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        osc_clk = 1'b0;
        #3;
        forever #32 osc_clk = ~osc_clk;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wb(input logic [7:0] d);
        logic [7:0] q;
        logic       a;
        host.xfer(d, q);
        host.bit_io(1'b1, a);
        chk("ack", 8'h00, {7'h00, a});
    endtask
    task automatic rb(input logic [7:0] e, input logic last);
        logic [7:0] q;
        logic       a;
        host.xfer(8'hFF, q);
        host.bit_io(last, a);
        chk("rdata", e, q);
    endtask
    task automatic setp(input logic [7:0] p, input logic rd);
        host.start();
        wb({DEV_ADDR_DEF, 1'b0});
        wb(p);
        if (rd) begin
            host.start();
            wb({DEV_ADDR_DEF, 1'b1});
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
    initial begin
        nrst = 1'b0;
        vcc_ok = 1'b0;
        osc_disable_n = 1'b1;
        irq_wave_select = 1'b1;
        alarm_irq = 1'b0;
        comp_code = 8'h5A;
        host.wt(12);
        nrst = 1'b1;
        host.wt(10);
        chk("rst_oe", 8'h01, {7'h00, rst_oe});
        vcc_ok = 1'b1;
        host.wt(10);
        chk("rst_oe", 8'h00, {7'h00, rst_oe});
        for (int k = 0; k < 260 && comp_req !== 1'b1; k++) host.wt(1);
        chk("comp_req", 8'h01, {7'h00, comp_req});
        host.wt(2);
        chk("comp_trim", 8'h5A, comp_trim);
        comp_code = 8'hA5;
        setp(8'h00, 1'b1);
        for (int k = 0; k < 7; k++) rb(init_v[k], k == 6);
        host.stop();
        setp(8'h12, 1'b0);
        wb(8'h00);
        wb(8'h46);
        wb(8'h13);
        host.stop();
        setp(8'h00, 1'b1);
        rb(8'h46, 1'b0);
        rb(8'h13, 1'b1);
        host.stop();
        foreach (addr_v[i]) begin
            setp(addr_v[i], 1'b0);
            wb(~addr_v[i]);
            host.stop();
            setp(addr_v[i], 1'b1);
            rb(~addr_v[i], 1'b1);
            host.stop();
        end
        host.push(1'b1);
        host.wt(8);
        chk("rst_oe", 8'h01, {7'h00, rst_oe});
        host.wt(80);
        chk("rst_oe", 8'h00, {7'h00, rst_oe});
        host.push(1'b0);
        host.wt(8);
        chk("rst_oe", 8'h01, {7'h00, rst_oe});
        host.wt(80);
        alarm_irq = 1'b1;
        host.wt(6);
        chk("irq_wave_out", 8'h00, {7'h00, irq_wave_out});
        chk("comp_trim", 8'hA5, comp_trim);
        osc_disable_n = 1'b0;
        host.wt(40);
        irq_wave_select = 1'b0;
        seen_wave = 2'b00;
        for (int k = 0; k < 160; k++) begin
            host.wt(1);
            seen_wave[irq_wave_out] = 1'b1;
        end
        chk("irq_wave_out", 8'h03, {6'h00, seen_wave});
        irq_wave_select = 1'b1;
        vcc_ok = 1'b0;
        host.wt(10);
        chk("rst_oe", 8'h01, {7'h00, rst_oe});
        vcc_ok = 1'b1;
        host.wt(150);
        chk("rst_oe", 8'h01, {7'h00, rst_oe});
        host.wt(100);
        chk("rst_oe", 8'h00, {7'h00, rst_oe});
        finish_test();
    end
endmodule
